// File: sioc_map.vh
// register offsets, field codes and reset values of the servo i/o configuration block
`ifndef SIOC_MAP_VH
`define SIOC_MAP_VH

// parameter addresses, as printed
`define SIOC_ADDR_NEG_LIMIT_EVALUATION 16'h061E
`define SIOC_ADDR_POS_LIMIT_EVALUATION 16'h0620
`define SIOC_ADDR_OUTPUT4_FUNCTION_SELECT 16'h071A
`define SIOC_ADDR_CURR_LIMIT_INPUT_EVALUATION 16'h0850

// reset values
`define SIOC_RST_NEG_LIMIT_EVALUATION 16'h0001
`define SIOC_RST_POS_LIMIT_EVALUATION 16'h0001
`define SIOC_RST_CURR_LIMIT_INPUT_EVALUATION 16'h0002
`define SIOC_RST_OUTPUT4_FUNCTION_SELECT 16'h0001

// evaluation codes
`define SIOC_EVAL_INACTIVE 16'h0000
`define SIOC_EVAL_NC 16'h0001
`define SIOC_EVAL_NO 16'h0002

// output 4 function codes
`define SIOC_FN_FREE 16'h0001
`define SIOC_FN_NO_FAULT 16'h0002
`define SIOC_FN_ACTIVE 16'h0003
`define SIOC_FN_REL_MOVE_CAPTURE 16'h0004
`define SIOC_FN_POS_WINDOW 16'h0005
`define SIOC_FN_VEL_WINDOW 16'h0006
`define SIOC_FN_VEL_BELOW 16'h0007
`define SIOC_FN_CURR_BELOW 16'h0008
`define SIOC_FN_HALT_ACK 16'h0009
`define SIOC_FN_STANDSTILL 16'h000D
`define SIOC_FN_SEL_ERROR 16'h000E
`define SIOC_FN_SEL_WARNING 16'h0010
`define SIOC_FN_MOVES_POS 16'h0016
`define SIOC_FN_MOVES_NEG 16'h0017

// answer codes on a refused access
`define SIOC_REJ_NONE 2'h0
`define SIOC_REJ_POWER_STAGE 2'h1
`define SIOC_REJ_RANGE 2'h2
`define SIOC_REJ_UNMAPPED 2'h3

`endif

// File: sioc_input_sync.v
// three-stage synchroniser with agreement filter for contact inputs
`timescale 1ns/10ps
`default_nettype none

module sioc_input_sync #(
	parameter WIDTH = 3
) (
	input wire clk,
	input wire rst_n,
	input wire clk_en,
	input wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);

genvar gi;
generate
	for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
		reg s1_q;
		reg s2_q;
		reg s3_q;
		reg out_q;
		always @(posedge clk) begin
			if (!rst_n) begin
				s1_q <= 1'b0;
				s2_q <= 1'b0;
				s3_q <= 1'b0;
				out_q <= 1'b0;
			end else if (clk_en) begin
				s1_q <= async_in[gi];
				s2_q <= s1_q;
				s3_q <= s2_q;
				// first stage is never looked at; change only once stages 2 and 3 agree
				if (s2_q == s3_q) begin
					out_q <= s3_q;
				end
			end
		end
		assign sync_out[gi] = out_q;
	end
endgenerate

endmodule // sioc_input_sync

`default_nettype wire

// File: sioc_contact_eval.v
// polarity evaluation of one contact input
`timescale 1ns/10ps
`default_nettype none
`include "sioc_map.vh"

module sioc_contact_eval (
	input wire [15:0] mode,
	input wire contact_closed,
	output reg active
);

always @* begin
	case (mode)
		// normally closed: opening the contact is the event
		`SIOC_EVAL_NC: active = ~contact_closed;
		`SIOC_EVAL_NO: active = contact_closed;
		default: active = 1'b0;
	endcase
end

endmodule // sioc_contact_eval

`default_nettype wire

// File: sioc_io_config.v
// output 4 function routing and limit/current-limit input evaluation for the servo i/o
`timescale 1ns/10ps
`default_nettype none
`include "sioc_map.vh"

module sioc_io_config (
	input wire REF_CLK,
	input wire RESET_N,
	input wire CLK_EN,
	// parameter access
	input wire [15:0] PARAM_ADDR,
	input wire [15:0] PARAM_WDATA,
	input wire PARAM_WR,
	input wire PARAM_RD,
	output wire [15:0] PARAM_RDATA,
	output wire PARAM_ACK,
	output wire PARAM_REJECT,
	output wire [1:0] PARAM_REJECT_CODE,
	// drive state
	input wire POWER_STAGE_EN,
	input wire STATE_READY_TO_SWITCH_ON,
	input wire STATE_SWITCHED_ON,
	input wire STATE_OPERATION_ENABLED,
	// internal status sources
	input wire RELATIVE_MOVE_AFTER_CAPTURE,
	input wire POS_DEVIATION_IN_WINDOW,
	input wire VEL_DEVIATION_IN_WINDOW,
	input wire VELOCITY_BELOW_THRESHOLD,
	input wire CURRENT_BELOW_THRESHOLD,
	input wire HALT_ACKNOWLEDGE,
	input wire MOTOR_STANDSTILL,
	input wire SELECTED_ERROR_ACTIVE,
	input wire SELECTED_WARNING_ACTIVE,
	input wire MOTOR_MOVES_POSITIVE,
	input wire MOTOR_MOVES_NEGATIVE,
	input wire FREE_OUTPUT4_VALUE,
	// contact pins, high means contact closed
	input wire CURRENT_LIMIT_CONTACT,
	input wire NEG_LIMIT_CONTACT,
	input wire POS_LIMIT_CONTACT,
	// results
	output wire DIGITAL_OUTPUT_4,
	output wire CURRENT_LIMIT_ACTIVE,
	output wire NEG_LIMIT_ACTIVE,
	output wire POS_LIMIT_ACTIVE,
	output wire [15:0] OUTPUT4_FUNCTION_ACTIVE
);

////////////////////////////////////////////////////////////////////////////////
// declarations

localparam NCH = 3;
localparam CH_CURR = 0;
localparam CH_NEG = 1;
localparam CH_POS = 2;

// persistent (stored) values, read back by the parameter port; factory values are
// power-up values, reset leaves them alone so a written selector survives a power-on
reg [15:0] stored_sel_q = `SIOC_RST_OUTPUT4_FUNCTION_SELECT;
reg [15:0] stored_curr_q = `SIOC_RST_CURR_LIMIT_INPUT_EVALUATION;
reg [15:0] stored_neg_q = `SIOC_RST_NEG_LIMIT_EVALUATION;
reg [15:0] stored_pos_q = `SIOC_RST_POS_LIMIT_EVALUATION;

// values steering the logic
reg [15:0] active_sel_q;
reg [15:0] active_curr_q;
reg [15:0] active_neg_q;
reg [15:0] active_pos_q;

reg boot_q;
reg pse_prev_q;

reg [15:0] rdata_q;
reg [15:0] rdata_d;
reg ack_q;
reg reject_q;
reg [1:0] reject_code_q;
reg [1:0] reject_code_d;

reg out4_q;
reg out4_d;
reg [NCH-1:0] in_active_q;

wire [NCH-1:0] contact_raw;
wire [NCH-1:0] contact_sync;
wire [NCH-1:0] eval_active;
wire [16*NCH-1:0] eval_modes;

wire req;
wire hit_sel;
wire hit_curr;
wire hit_neg;
wire hit_pos;
wire mapped;
wire value_ok;
wire wr_accept;
wire pse_rise;

////////////////////////////////////////////////////////////////////////////////
// range checks

function sel_valid;
	input [15:0] v;
	begin
		case (v)
			`SIOC_FN_FREE, `SIOC_FN_NO_FAULT, `SIOC_FN_ACTIVE, `SIOC_FN_REL_MOVE_CAPTURE,
			`SIOC_FN_POS_WINDOW, `SIOC_FN_VEL_WINDOW, `SIOC_FN_VEL_BELOW,
			`SIOC_FN_CURR_BELOW, `SIOC_FN_HALT_ACK, `SIOC_FN_STANDSTILL,
			`SIOC_FN_SEL_ERROR, `SIOC_FN_SEL_WARNING, `SIOC_FN_MOVES_POS,
			`SIOC_FN_MOVES_NEG: sel_valid = 1'b1;
			default: sel_valid = 1'b0;
		endcase
	end
endfunction

// current limitation has no inactive setting
function curr_valid;
	input [15:0] v;
	begin
		curr_valid = (v == `SIOC_EVAL_NC) || (v == `SIOC_EVAL_NO);
	end
endfunction

function limit_valid;
	input [15:0] v;
	begin
		limit_valid = (v == `SIOC_EVAL_INACTIVE) || (v == `SIOC_EVAL_NC) ||
			(v == `SIOC_EVAL_NO);
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// parameter access decode

assign req = PARAM_WR | PARAM_RD;
assign hit_sel = (PARAM_ADDR == `SIOC_ADDR_OUTPUT4_FUNCTION_SELECT);
assign hit_curr = (PARAM_ADDR == `SIOC_ADDR_CURR_LIMIT_INPUT_EVALUATION);
assign hit_neg = (PARAM_ADDR == `SIOC_ADDR_NEG_LIMIT_EVALUATION);
assign hit_pos = (PARAM_ADDR == `SIOC_ADDR_POS_LIMIT_EVALUATION);
assign mapped = hit_sel | hit_curr | hit_neg | hit_pos;

assign value_ok = (hit_sel & sel_valid(PARAM_WDATA)) |
	(hit_curr & curr_valid(PARAM_WDATA)) |
	(hit_neg & limit_valid(PARAM_WDATA)) |
	(hit_pos & limit_valid(PARAM_WDATA));

// write wins when both strobes come together
assign wr_accept = PARAM_WR & mapped & value_ok & ~POWER_STAGE_EN;

always @* begin
	reject_code_d = `SIOC_REJ_NONE;
	if (!mapped) begin
		reject_code_d = `SIOC_REJ_UNMAPPED;
	end else if (PARAM_WR && POWER_STAGE_EN) begin
		reject_code_d = `SIOC_REJ_POWER_STAGE;
	end else if (PARAM_WR && !value_ok) begin
		reject_code_d = `SIOC_REJ_RANGE;
	end
end

always @* begin
	rdata_d = 16'h0000;
	if (hit_sel) begin
		rdata_d = stored_sel_q;
	end else if (hit_curr) begin
		rdata_d = stored_curr_q;
	end else if (hit_neg) begin
		rdata_d = stored_neg_q;
	end else if (hit_pos) begin
		rdata_d = stored_pos_q;
	end
end

always @(posedge REF_CLK) begin
	if (!RESET_N) begin
		ack_q <= 1'b0;
		reject_q <= 1'b0;
		reject_code_q <= `SIOC_REJ_NONE;
		rdata_q <= 16'h0000;
	end else if (CLK_EN) begin
		ack_q <= req;
		if (req) begin
			reject_q <= (reject_code_d != `SIOC_REJ_NONE);
			reject_code_q <= reject_code_d;
			// a write answers with zero data
			rdata_q <= PARAM_WR ? 16'h0000 : rdata_d;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// stored settings

// no reset branch: a reset resetting these would wipe a selector before it can act
always @(posedge REF_CLK) begin
	if (RESET_N && CLK_EN && wr_accept) begin
		if (hit_sel) begin
			stored_sel_q <= PARAM_WDATA;
		end
		if (hit_curr) begin
			stored_curr_q <= PARAM_WDATA;
		end
		if (hit_neg) begin
			stored_neg_q <= PARAM_WDATA;
		end
		if (hit_pos) begin
			stored_pos_q <= PARAM_WDATA;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// activation of settings

assign pse_rise = POWER_STAGE_EN & ~pse_prev_q;

// selector is taken once per power-on, i.e. at the first edge with CLK_EN high after reset release
always @(posedge REF_CLK) begin
	if (!RESET_N) begin
		boot_q <= 1'b1;
		active_sel_q <= `SIOC_RST_OUTPUT4_FUNCTION_SELECT;
	end else if (CLK_EN) begin
		boot_q <= 1'b0;
		if (boot_q) begin
			active_sel_q <= stored_sel_q;
		end
	end
end

// evaluation modes follow the stored ones only on power stage enable
always @(posedge REF_CLK) begin
	if (!RESET_N) begin
		pse_prev_q <= 1'b0;
		active_curr_q <= `SIOC_RST_CURR_LIMIT_INPUT_EVALUATION;
		active_neg_q <= `SIOC_RST_NEG_LIMIT_EVALUATION;
		active_pos_q <= `SIOC_RST_POS_LIMIT_EVALUATION;
	end else if (CLK_EN) begin
		pse_prev_q <= POWER_STAGE_EN;
		if (pse_rise) begin
			active_curr_q <= stored_curr_q;
			active_neg_q <= stored_neg_q;
			active_pos_q <= stored_pos_q;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// contact inputs

assign contact_raw[CH_CURR] = CURRENT_LIMIT_CONTACT;
assign contact_raw[CH_NEG] = NEG_LIMIT_CONTACT;
assign contact_raw[CH_POS] = POS_LIMIT_CONTACT;

assign eval_modes[16*CH_CURR +: 16] = active_curr_q;
assign eval_modes[16*CH_NEG +: 16] = active_neg_q;
assign eval_modes[16*CH_POS +: 16] = active_pos_q;

sioc_input_sync #(
	.WIDTH(NCH)
) u_sync (
	.clk(REF_CLK),
	.rst_n(RESET_N),
	.clk_en(CLK_EN),
	.async_in(contact_raw),
	.sync_out(contact_sync)
);

genvar gc;
generate
	for (gc = 0; gc < NCH; gc = gc + 1) begin : g_eval
		sioc_contact_eval u_eval (
			.mode(eval_modes[16*gc +: 16]),
			.contact_closed(contact_sync[gc]),
			.active(eval_active[gc])
		);
	end
endgenerate

always @(posedge REF_CLK) begin
	if (!RESET_N) begin
		in_active_q <= {NCH{1'b0}};
	end else if (CLK_EN) begin
		in_active_q <= eval_active;
	end
end

////////////////////////////////////////////////////////////////////////////////
// output 4 routing

always @* begin
	case (active_sel_q)
		`SIOC_FN_FREE: out4_d = FREE_OUTPUT4_VALUE;
		`SIOC_FN_NO_FAULT: out4_d = STATE_READY_TO_SWITCH_ON | STATE_SWITCHED_ON |
			STATE_OPERATION_ENABLED;
		`SIOC_FN_ACTIVE: out4_d = STATE_OPERATION_ENABLED;
		`SIOC_FN_REL_MOVE_CAPTURE: out4_d = RELATIVE_MOVE_AFTER_CAPTURE;
		`SIOC_FN_POS_WINDOW: out4_d = POS_DEVIATION_IN_WINDOW;
		`SIOC_FN_VEL_WINDOW: out4_d = VEL_DEVIATION_IN_WINDOW;
		`SIOC_FN_VEL_BELOW: out4_d = VELOCITY_BELOW_THRESHOLD;
		`SIOC_FN_CURR_BELOW: out4_d = CURRENT_BELOW_THRESHOLD;
		`SIOC_FN_HALT_ACK: out4_d = HALT_ACKNOWLEDGE;
		`SIOC_FN_STANDSTILL: out4_d = MOTOR_STANDSTILL;
		`SIOC_FN_SEL_ERROR: out4_d = SELECTED_ERROR_ACTIVE;
		`SIOC_FN_SEL_WARNING: out4_d = SELECTED_WARNING_ACTIVE;
		`SIOC_FN_MOVES_POS: out4_d = MOTOR_MOVES_POSITIVE;
		`SIOC_FN_MOVES_NEG: out4_d = MOTOR_MOVES_NEGATIVE;
		// unreachable through writes; keeps the pin safe off
		default: out4_d = 1'b0;
	endcase
end

always @(posedge REF_CLK) begin
	if (!RESET_N) begin
		out4_q <= 1'b0;
	end else if (CLK_EN) begin
		out4_q <= out4_d;
	end
end

////////////////////////////////////////////////////////////////////////////////
// outputs

assign PARAM_RDATA = rdata_q;
assign PARAM_ACK = ack_q;
assign PARAM_REJECT = reject_q;
assign PARAM_REJECT_CODE = reject_code_q;
assign DIGITAL_OUTPUT_4 = out4_q;
assign CURRENT_LIMIT_ACTIVE = in_active_q[CH_CURR];
assign NEG_LIMIT_ACTIVE = in_active_q[CH_NEG];
assign POS_LIMIT_ACTIVE = in_active_q[CH_POS];
assign OUTPUT4_FUNCTION_ACTIVE = active_sel_q;

endmodule // sioc_io_config

`default_nettype wire

// File: sioc_contact_model.sv
// contact model: limit switches and current-limit contact as seen at the pins
`timescale 1ns/10ps
`default_nettype none
module sioc_contact_model (
	input wire logic [2:0] closed,
	output logic cur_pin,
	output logic neg_pin,
	output logic pos_pin
);
	// a closed contact drives its pin high; the pins are never left floating
	assign {cur_pin, neg_pin, pos_pin} = closed;
endmodule // sioc_contact_model
`default_nettype wire

// File: sioc_io_config_chk.sv
// port assertions for the servo i/o configuration block
`timescale 1ns/10ps
`default_nettype none
module sioc_chk (
	input wire logic REF_CLK,
	input wire logic RESET_N,
	input wire logic CLK_EN,
	input wire logic [15:0] PARAM_ADDR,
	input wire logic [15:0] PARAM_WDATA,
	input wire logic PARAM_WR,
	input wire logic PARAM_RD,
	input wire logic [15:0] PARAM_RDATA,
	input wire logic PARAM_ACK,
	input wire logic PARAM_REJECT,
	input wire logic [1:0] PARAM_REJECT_CODE,
	input wire logic POWER_STAGE_EN,
	input wire logic STATE_READY_TO_SWITCH_ON,
	input wire logic STATE_SWITCHED_ON,
	input wire logic STATE_OPERATION_ENABLED,
	input wire logic FREE_OUTPUT4_VALUE,
	input wire logic DIGITAL_OUTPUT_4,
	input wire logic [15:0] OUTPUT4_FUNCTION_ACTIVE
);
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RESET_N);
	////////////////////////////////////////////////////////////////
	a_ack_next: assert property ((PARAM_WR || PARAM_RD) && CLK_EN |=> PARAM_ACK)
		else $error("no answer after request");
	a_power_refuse:
	assert property (PARAM_WR && CLK_EN && POWER_STAGE_EN && PARAM_ADDR == 16'h071A
		|=> PARAM_REJECT && PARAM_REJECT_CODE == 2'h1) else $error("write taken with power on");
	a_curr_range:
	assert property (PARAM_WR && CLK_EN && !POWER_STAGE_EN && PARAM_ADDR == 16'h0850
		&& (PARAM_WDATA == 16'h0000 || PARAM_WDATA > 16'h0002)
		|=> PARAM_REJECT && PARAM_REJECT_CODE == 2'h2) else $error("bad current mode taken");
	a_neg_range:
	assert property (PARAM_WR && CLK_EN && !POWER_STAGE_EN && PARAM_ADDR == 16'h061E
		&& PARAM_WDATA > 16'h0002 |=> PARAM_REJECT_CODE == 2'h2) else $error("bad neg mode taken");
	a_pos_accept:
	assert property (PARAM_WR && CLK_EN && !POWER_STAGE_EN && PARAM_ADDR == 16'h0620
		&& PARAM_WDATA <= 16'h0002 |=> !PARAM_REJECT) else $error("legal pos mode refused");
	a_unmapped_read:
	assert property (PARAM_RD && !PARAM_WR && CLK_EN && PARAM_ADDR == 16'h0700
		|=> PARAM_REJECT_CODE == 2'h3 && PARAM_RDATA == 16'h0000) else $error("unmapped read");
	a_sel_hold:
	assert property ($past(RESET_N) && $past(RESET_N, 2) |-> $stable(OUTPUT4_FUNCTION_ACTIVE))
		else $error("selector changed without reset");
	a_no_fault:
	assert property ($past(CLK_EN) && OUTPUT4_FUNCTION_ACTIVE == 16'h0002
		&& $past(OUTPUT4_FUNCTION_ACTIVE) == 16'h0002 |-> DIGITAL_OUTPUT_4 == $past(
		STATE_READY_TO_SWITCH_ON || STATE_SWITCHED_ON || STATE_OPERATION_ENABLED))
		else $error("output 4 wrong for state selector");
	a_free_value:
	assert property ($past(CLK_EN) && $past(RESET_N) && OUTPUT4_FUNCTION_ACTIVE == 16'h0001
		&& $past(OUTPUT4_FUNCTION_ACTIVE) == 16'h0001
		|-> DIGITAL_OUTPUT_4 == $past(FREE_OUTPUT4_VALUE)) else $error("free value not shown");
endmodule // sioc_chk
bind sioc_io_config sioc_chk u_chk (.*);
`default_nettype wire

// File: sioc_tb.sv
// self-checking bench for the servo i/o configuration block
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic REF_CLK, RESET_N, CLK_EN, PARAM_WR, PARAM_RD, POWER_STAGE_EN;
	logic [15:0] PARAM_ADDR, PARAM_WDATA, rdata;
	wire [15:0] PARAM_RDATA, OUTPUT4_FUNCTION_ACTIVE;
	wire [1:0] PARAM_REJECT_CODE;
	wire PARAM_ACK, PARAM_REJECT, DIGITAL_OUTPUT_4;
	wire CURRENT_LIMIT_ACTIVE, NEG_LIMIT_ACTIVE, POS_LIMIT_ACTIVE;
	wire CURRENT_LIMIT_CONTACT, NEG_LIMIT_CONTACT, POS_LIMIT_CONTACT;
	wire STATE_READY_TO_SWITCH_ON, STATE_SWITCHED_ON, STATE_OPERATION_ENABLED;
	wire RELATIVE_MOVE_AFTER_CAPTURE, POS_DEVIATION_IN_WINDOW, VEL_DEVIATION_IN_WINDOW;
	wire VELOCITY_BELOW_THRESHOLD, CURRENT_BELOW_THRESHOLD, HALT_ACKNOWLEDGE;
	wire MOTOR_STANDSTILL, SELECTED_ERROR_ACTIVE, SELECTED_WARNING_ACTIVE;
	wire MOTOR_MOVES_POSITIVE, MOTOR_MOVES_NEGATIVE, FREE_OUTPUT4_VALUE;
	logic [11:0] src;
	logic [2:0] st, closed;
	logic rej;
	logic [1:0] rcode;
	int failures, comparisons, cycles;
	assign {FREE_OUTPUT4_VALUE, MOTOR_MOVES_NEGATIVE, MOTOR_MOVES_POSITIVE,
		SELECTED_WARNING_ACTIVE, SELECTED_ERROR_ACTIVE, MOTOR_STANDSTILL, HALT_ACKNOWLEDGE,
		CURRENT_BELOW_THRESHOLD, VELOCITY_BELOW_THRESHOLD, VEL_DEVIATION_IN_WINDOW,
		POS_DEVIATION_IN_WINDOW, RELATIVE_MOVE_AFTER_CAPTURE} = src;
	assign {STATE_OPERATION_ENABLED, STATE_SWITCHED_ON, STATE_READY_TO_SWITCH_ON} = st;
	sioc_io_config dut (.*);
	sioc_contact_model u_contacts (.closed(closed), .cur_pin(CURRENT_LIMIT_CONTACT),
		.neg_pin(NEG_LIMIT_CONTACT), .pos_pin(POS_LIMIT_CONTACT));
	////////////////////////////////////////////////////////////////
	initial begin
		REF_CLK = 0;
		forever #5 REF_CLK = ~REF_CLK;
	end
	// ceiling well above the some 830 cycles the tests need
	always @(posedge REF_CLK) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			complete_run;
		end
	end
	task automatic complete_run;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge REF_CLK);
		#1;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one strobe pulse, answer sampled in the following cycle
	task automatic acc(input logic wr, input logic [15:0] a, input logic [15:0] d);
		PARAM_WR = wr;
		PARAM_RD = !wr;
		PARAM_ADDR = a;
		PARAM_WDATA = d;
		step(1);
		rdata = PARAM_RDATA;
		rej = PARAM_REJECT;
		rcode = PARAM_REJECT_CODE;
		chk(PARAM_ACK, 16'h0001);
		PARAM_WR = 0;
		PARAM_RD = 0;
		step(1);
	endtask
	task automatic do_reset;
		RESET_N = 0;
		step(16);
		RESET_N = 1;
		step(2);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_regs;
		logic [31:0] dflt [4] = '{32'h061E_0001, 32'h0620_0001, 32'h071A_0001, 32'h0850_0002};
		chk(OUTPUT4_FUNCTION_ACTIVE, 16'h0001);
		for (int i = 0; i < 4; i++) begin
			acc(0, dflt[i][31:16], 16'h0000);
			chk(rdata, dflt[i][15:0]);
		end
		acc(0, 16'h0700, 16'h0000);
		chk(rcode, 2'h3);
		CLK_EN = 0;
		PARAM_RD = 1;
		step(1);
		chk(PARAM_ACK, 16'h0000);
		PARAM_RD = 0;
		CLK_EN = 1;
		step(1);
		$display("test regs done");
	endtask
	task automatic t_range;
		logic [31:0] bad [5] = '{32'h0850_0000, 32'h0850_0003, 32'h061E_0003,
			32'h0620_0003, 32'h071A_000A};
		for (int i = 0; i < 5; i++) begin
			acc(1, bad[i][31:16], bad[i][15:0]);
			chk(rcode, 2'h2);
		end
		$display("test range done");
	endtask
	task automatic t_eval;
		chk({CURRENT_LIMIT_ACTIVE, NEG_LIMIT_ACTIVE, POS_LIMIT_ACTIVE}, 3'h4);
		acc(1, 16'h0850, 16'h0001);
		acc(1, 16'h061E, 16'h0002);
		acc(1, 16'h0620, 16'h0000);
		chk(rej, 1'b0);
		step(4);
		chk({CURRENT_LIMIT_ACTIVE, NEG_LIMIT_ACTIVE, POS_LIMIT_ACTIVE}, 3'h4);
		POWER_STAGE_EN = 1;
		step(3);
		chk({CURRENT_LIMIT_ACTIVE, NEG_LIMIT_ACTIVE, POS_LIMIT_ACTIVE}, 3'h2);
		closed = 3'h0;
		step(8);
		chk({CURRENT_LIMIT_ACTIVE, NEG_LIMIT_ACTIVE, POS_LIMIT_ACTIVE}, 3'h4);
		acc(1, 16'h061E, 16'h0001);
		chk(rcode, 2'h1);
		acc(0, 16'h061E, 16'h0000);
		chk(rdata, 16'h0002);
		POWER_STAGE_EN = 0;
		$display("test eval done");
	endtask
	// source that each selector code should put on output 4
	function automatic logic exp4(input int c);
		case (c)
			1: return src[11];
			2: return |st;
			3: return st[2];
			13: return src[6];
			14: return src[7];
			16: return src[8];
			22: return src[9];
			23: return src[10];
			default: return src[c - 4];
		endcase
	endfunction
	task automatic t_sel;
		int codes [14] = '{1, 2, 3, 4, 5, 6, 7, 8, 9, 13, 14, 16, 22, 23};
		int prev = 1;
		for (int i = 0; i < 14; i++) begin
			acc(1, 16'h071A, 16'(codes[i]));
			acc(0, 16'h071A, 16'h0000);
			chk(rdata, 16'(codes[i]));
			chk(OUTPUT4_FUNCTION_ACTIVE, 16'(prev));
			// power-on is reset here; the stored selector takes over
			do_reset;
			chk(OUTPUT4_FUNCTION_ACTIVE, 16'(codes[i]));
			for (int p = 0; p < 32; p++) begin
				src = p[4] ? ~(12'h001 << p[3:0]) : 12'h001 << p[3:0];
				st = p[2:0];
				step(1);
				chk(DIGITAL_OUTPUT_4, exp4(codes[i]));
			end
			prev = codes[i];
		end
		$display("test sel done");
	endtask
	initial begin
		RESET_N = 0;
		CLK_EN = 1;
		PARAM_WR = 0;
		PARAM_RD = 0;
		PARAM_ADDR = 0;
		PARAM_WDATA = 0;
		POWER_STAGE_EN = 0;
		src = 0;
		st = 0;
		closed = 3'h7;
		do_reset;
		step(8);
		t_regs;
		t_range;
		t_eval;
		t_sel;
		complete_run;
	end
endmodule // tb
`default_nettype wire
